// ---- verilog/pfs_pkg.sv ----
// Purpose: Constants for the protection function switch logic
// Assumes: AHB-Lite register access, 32-bit data, 40 MHz REF_CLK
// Notes: Offsets and reset values are named here once
package pfs_pkg;
   // Register byte offsets
   localparam logic [7:0] PFS_OFF_FUNC = 8'h00;
   localparam logic [7:0] PFS_OFF_CHAR = 8'h04;
   localparam logic [7:0] PFS_OFF_STAT = 8'h08;
   localparam logic [7:0] PFS_OFF_RST = 8'h0C;
   localparam logic [7:0] PFS_OFF_STG = 8'h10;
   // Reset values: all switches cleared, characteristic code zero
   localparam logic [7:0] PFS_FUNC_RST = 8'h00;
   localparam logic [2:0] PFS_CHAR_RST = 3'h0;
   // Function switch bit positions (switch n sits in bit n-1)
   localparam int PFS_B_HOLD0 = 0;
   localparam int PFS_B_HPDIS = 4;
   localparam int PFS_B_HEDIS = 5;
   localparam int PFS_B_AR1EN = 6;
   localparam int PFS_B_AR3SEL = 7;
   // Stage indices: low phase, high phase, low earth, high earth
   localparam int PFS_STG_LP = 0;
   localparam int PFS_STG_HP = 1;
   localparam int PFS_STG_LE = 2;
   localparam int PFS_STG_HE = 3;
   // Characteristic codes
   typedef enum logic [2:0] {
      PFS_CH_DT = 3'b000,
      PFS_CH_EI = 3'b001,
      PFS_CH_VI = 3'b010,
      PFS_CH_NI = 3'b011,
      PFS_CH_LTI = 3'b100,
      PFS_CH_RI = 3'b101,
      PFS_CH_RX = 3'b110,
      PFS_CH_UNUSED = 3'b111
   } pfs_char_t;
   // AHB transfer type
   localparam logic [1:0] PFS_HTRANS_NONSEQ = 2'h2;
endpackage

// ---- verilog/pfs_ind.sv ----
// Purpose: Start indication for one protection stage
// Assumes: Start input is already synchronised to REF_CLK
// Notes: Hold mode keeps the flag until a manual reset pulse
module pfs_ind (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic hold_mode,
   input wire logic man_rst,
   output logic ind
);
   logic ind_r;
   logic ind_nxt;
   // Start wins over reset so an event is never lost
   assign ind_nxt = start ? 1'b1 :
                    (hold_mode ? (ind_r & ~man_rst) : 1'b0);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ind_r <= 1'b0;
      end else begin
         ind_r <= ind_nxt;
      end
   end
   assign ind = ind_r;
endmodule

// ---- verilog/pfs_top.sv ----
// Purpose: Applies function switches to overcurrent and earth stages
// Assumes: Stage starts arrive from outside the clock domain
// Notes: Registers reached over AHB-Lite, zero wait states
// How it works
// - Characteristic code all ones is treated as long-time inverse.
// - Characteristic switches reset to zero.
// - Cleared hold switch: start indication follows the fault and self clears.
// - Hold switch set: indication stays until manual reset; bits 0..3 per stage.
// - Switch five set disables the high-set phase stage, display dashes.
// - Switch six set disables the high-set earth stage, display dashes.
// - Switch seven set drives high-set phase start to first reclose output.
// - First reclose output and third signal output always equal.
// - Switch seven clear keeps high-set phase start off both outputs.
// - Switch eight picks low or high earth start for third reclose output.
// - Function switches reset to zero.
module pfs_top (
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [3:0] STAGE_START,
   output logic [3:0] START_IND,
   output logic [1:0] STAGE_ACTIVE,
   output logic [1:0] DISPLAY_DASHES,
   output logic [2:0] DEPENDENT_TIME_MODE,
   output logic RECLOSE_OUTPUT_FIRST,
   output logic RECLOSE_OUTPUT_THIRD,
   output logic SIGNAL_OUTPUT_THIRD
);
   import pfs_pkg::*;

   logic [7:0] func_r;
   logic [7:0] func_nxt;
   logic [2:0] char_r;
   logic [2:0] char_nxt;
   logic [3:0] start_s1_r;
   logic [3:0] start_s2_r;
   logic [3:0] ind_w;
   logic [3:0] man_rst_r;
   logic [3:0] man_rst_nxt;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [3:0] ind_r;
   logic [1:0] act_r;
   logic [1:0] dash_r;
   logic [2:0] mode_r;
   logic ar1_r;
   logic ar3_r;
   logic ss3_r;

   // Maps the unused all-ones code onto long-time inverse
   function automatic logic [2:0] eff_char(input logic [2:0] code);
      eff_char = (code == PFS_CH_UNUSED) ? PFS_CH_LTI : code;
   endfunction

   // Bus decode
   wire addr_ph = HSEL & HREADY & HTRANS[1];
   wire wr_ph = addr_ph & HWRITE;
   wire rd_ph = addr_ph & ~HWRITE;
   wire wr_func = wr_pend_r & (wr_addr_r == PFS_OFF_FUNC);
   wire wr_char = wr_pend_r & (wr_addr_r == PFS_OFF_CHAR);
   wire wr_rst = wr_pend_r & (wr_addr_r == PFS_OFF_RST);

   // Register next values
   assign func_nxt = wr_func ? HWDATA[7:0] : func_r;
   assign char_nxt = wr_char ? HWDATA[2:0] : char_r;
   assign man_rst_nxt = wr_rst ? HWDATA[3:0] : 4'h0;

   // Stage enables: high-set stages drop out when their switch is set
   wire hp_en = ~func_r[PFS_B_HPDIS];
   wire he_en = ~func_r[PFS_B_HEDIS];
   wire [3:0] stage_en = {he_en, 1'b1, hp_en, 1'b1};
   wire [3:0] start_q = start_s2_r & stage_en;

   // Read mux, decoded in the address phase so that the registered
   // word stands during the zero-wait data phase; unmapped reads zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rd_ph) begin
         case (HADDR[7:0])
            PFS_OFF_FUNC: rdata_nxt = {24'h00_0000, func_r};
            PFS_OFF_CHAR: rdata_nxt = {29'h0, char_r};
            PFS_OFF_STAT: rdata_nxt = {28'h0, ind_r};
            PFS_OFF_STG: rdata_nxt = {28'h0, start_q};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Routing of starts to reclose and signal outputs
   wire ar1_nxt = func_r[PFS_B_AR1EN] & start_q[PFS_STG_HP];
   wire ar3_nxt = func_r[PFS_B_AR3SEL] ? start_q[PFS_STG_HE]
                                       : start_q[PFS_STG_LE];

   // Per-stage start indication; hold bits are the low four switches
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ind
         pfs_ind u_ind (
            .clk(REF_CLK),
            .arst_n(ARST_N),
            .start(start_q[g]),
            .hold_mode(func_r[PFS_B_HOLD0 + g]),
            .man_rst(man_rst_r[g]),
            .ind(ind_w[g])
         );
      end
   endgenerate

   // Start input synchroniser
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         start_s1_r <= 4'h0;
         start_s2_r <= 4'h0;
      end else begin
         start_s1_r <= STAGE_START;
         start_s2_r <= start_s1_r;
      end
   end

   // Switch registers, cleared on reset
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         func_r <= PFS_FUNC_RST;
         char_r <= PFS_CHAR_RST;
         man_rst_r <= 4'h0;
      end else begin
         func_r <= func_nxt;
         char_r <= char_nxt;
         man_rst_r <= man_rst_nxt;
      end
   end

   // Bus phase tracking
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= wr_ph;
         if (wr_ph) begin
            wr_addr_r <= HADDR[7:0];
         end
         rdata_r <= rdata_nxt;
      end
   end

   // Registered outputs follow switch changes in one cycle, START_IND in two
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ind_r <= 4'h0;
         act_r <= 2'h3;
         dash_r <= 2'h0;
         mode_r <= PFS_CH_DT;
         ar1_r <= 1'b0;
         ar3_r <= 1'b0;
         ss3_r <= 1'b0;
      end else begin
         ind_r <= ind_w;
         act_r <= {he_en, hp_en};
         dash_r <= {~he_en, ~hp_en};
         mode_r <= eff_char(char_r);
         ar1_r <= ar1_nxt;
         ar3_r <= ar3_nxt;
         ss3_r <= ar1_nxt;
      end
   end

   assign START_IND = ind_r;
   assign STAGE_ACTIVE = act_r;
   assign DISPLAY_DASHES = dash_r;
   assign DEPENDENT_TIME_MODE = mode_r;
   assign RECLOSE_OUTPUT_FIRST = ar1_r;
   assign RECLOSE_OUTPUT_THIRD = ar3_r;
   assign SIGNAL_OUTPUT_THIRD = ss3_r;
   assign HRDATA = rdata_r;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
endmodule

// ---- test/pfs_ar_model.sv ----
// Purpose: Far side auto-reclose logic that counts reclose starts
// Assumes: Reclose outputs are levels in the REF_CLK domain
// Notes: A start is a rising edge of the OR of both reclose outputs
module pfs_ar_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ar_first,
   input wire logic ar_third,
   output logic [7:0] shots
);
   timeunit 1ns;
   timeprecision 1ps;
   logic any_r;
   // Count each new reclose request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         any_r <= 1'b0;
         shots <= 8'h00;
      end else begin
         any_r <= ar_first | ar_third;
         if ((ar_first | ar_third) && !any_r) shots <= shots + 8'h01;
      end
   end
endmodule

// ---- test/pfs_properties.sv ----
// Purpose: Port level checks of the switch logic
// Assumes: Starts reach routing outputs three edges later
// Notes: Bound to pfs_top from the bench top file
module pfs_properties (
   input wire logic REF_CLK,
   input wire logic ARST_N,
   input wire logic [3:0] STAGE_START,
   input wire logic [3:0] START_IND,
   input wire logic [1:0] STAGE_ACTIVE,
   input wire logic [1:0] DISPLAY_DASHES,
   input wire logic [2:0] DEPENDENT_TIME_MODE,
   input wire logic RECLOSE_OUTPUT_FIRST,
   input wire logic RECLOSE_OUTPUT_THIRD,
   input wire logic SIGNAL_OUTPUT_THIRD,
   input wire logic HREADYOUT,
   input wire logic HRESP
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   // Joined outputs, dashes and characteristic code
   property p_join; RECLOSE_OUTPUT_FIRST == SIGNAL_OUTPUT_THIRD; endproperty
   a_join: assert property (p_join) else $error("joined outputs differ");
   property p_hp; STAGE_ACTIVE[0] != DISPLAY_DASHES[0]; endproperty
   a_hp: assert property (p_hp) else $error("phase dashes wrong");
   property p_he; STAGE_ACTIVE[1] != DISPLAY_DASHES[1]; endproperty
   a_he: assert property (p_he) else $error("earth dashes wrong");
   property p_lt; DEPENDENT_TIME_MODE != 3'h7; endproperty
   a_lt: assert property (p_lt) else $error("unused code shown");
   // Routing outputs need a matching start three edges back
   property p_ar1; RECLOSE_OUTPUT_FIRST |-> $past(STAGE_START[1], 3);
   endproperty
   a_ar1: assert property (p_ar1) else $error("first without start");
   property p_ar3;
      RECLOSE_OUTPUT_THIRD |-> $past(STAGE_START[2] | STAGE_START[3], 3);
   endproperty
   a_ar3: assert property (p_ar3) else $error("third without start");
   property p_ind;
      $rose(START_IND[0]) |->
         $past(STAGE_START[0], 3) || $past(STAGE_START[0], 4);
   endproperty
   a_ind: assert property (p_ind) else $error("indication uncaused");
   property p_bus; HREADYOUT && !HRESP; endproperty
   a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule

// ---- test/protection_function_switch_logic_tb.sv ----
// Purpose: Self-checking bench for the switch logic
// Assumes: Zero wait AHB-Lite slave, one clock
// Notes: Each scenario is a task that judges its own results
module protection_function_switch_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pfs_pkg::*;
   logic REF_CLK = 0, ARST_N = 0, HSEL = 0, HWRITE = 0, HREADY;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
   logic [1:0] HTRANS = 0, STAGE_ACTIVE, DISPLAY_DASHES;
   logic [2:0] HSIZE = 3'h2, DEPENDENT_TIME_MODE;
   logic [3:0] STAGE_START = 0, START_IND;
   logic HREADYOUT, HRESP, RECLOSE_OUTPUT_FIRST, RECLOSE_OUTPUT_THIRD;
   logic SIGNAL_OUTPUT_THIRD;
   logic [7:0] shots;
   int n_fail = 0, compares = 0;
   assign HREADY = HREADYOUT;
   pfs_top dut_u (.REF_CLK, .ARST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
      .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .STAGE_START, .START_IND,
      .STAGE_ACTIVE, .DISPLAY_DASHES, .DEPENDENT_TIME_MODE, .SIGNAL_OUTPUT_THIRD,
      .RECLOSE_OUTPUT_FIRST, .RECLOSE_OUTPUT_THIRD);
   pfs_ar_model far_u (.clk(REF_CLK), .arst_n(ARST_N), .shots(shots),
      .ar_first(RECLOSE_OUTPUT_FIRST), .ar_third(RECLOSE_OUTPUT_THIRD));
   initial forever #12.5 REF_CLK = ~REF_CLK;
   // Compare, count and end the run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Bus master: wait for ready at an edge, bounded
   task rdy;
      int i;
      i = 0;
      @(posedge REF_CLK);
      while (HREADY !== 1'b1 && i < 20) begin
         @(posedge REF_CLK);
         i++;
      end
      if (i == 20) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge REF_CLK);
      HSEL <= 1'b1;
      HTRANS <= PFS_HTRANS_NONSEQ;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      rdy();
      HTRANS <= 2'h0;
      HWDATA <= d;
      rdy();
      q = HRDATA;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task tick(input int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask
   task go(input logic [3:0] s);
      @(posedge REF_CLK);
      STAGE_START <= s;
      tick(6);
   endtask
   // Scenarios
   task t_reg;
      rd(PFS_OFF_FUNC, 32'h0);
      rd(PFS_OFF_CHAR, 32'h0);
      rd(8'h40, 32'h0);
      wr(PFS_OFF_CHAR, 32'h7);
      tick(2);
      chk(DEPENDENT_TIME_MODE, PFS_CH_LTI);
      wr(PFS_OFF_FUNC, 32'h30);
      tick(1);
      chk(STAGE_ACTIVE, 2'b00);
      chk(DISPLAY_DASHES, 2'b11);
      wr(PFS_OFF_FUNC, 32'h0);
      tick(1);
      chk(STAGE_ACTIVE, 2'b11);
      $display("test registers done");
   endtask
   task t_route;
      wr(PFS_OFF_FUNC, 32'h40);
      go(4'h2);
      chk(RECLOSE_OUTPUT_FIRST, 1'b1);
      chk(SIGNAL_OUTPUT_THIRD, 1'b1);
      go(4'h0);
      wr(PFS_OFF_FUNC, 32'h0);
      go(4'h2);
      chk({RECLOSE_OUTPUT_FIRST, SIGNAL_OUTPUT_THIRD}, 2'b00);
      go(4'h4);
      chk(RECLOSE_OUTPUT_THIRD, 1'b1);
      go(4'h8);
      chk(RECLOSE_OUTPUT_THIRD, 1'b0);
      wr(PFS_OFF_FUNC, 32'h80);
      tick(2);
      chk(RECLOSE_OUTPUT_THIRD, 1'b1);
      go(4'h0);
      chk(shots, 8'h03);
      $display("test routing done");
   endtask
   task t_ind;
      wr(PFS_OFF_FUNC, 32'h01);
      go(4'h1);
      go(4'h0);
      chk(START_IND[0], 1'b1);
      wr(PFS_OFF_RST, 32'h1);
      tick(3);
      chk(START_IND[0], 1'b0);
      wr(PFS_OFF_FUNC, 32'h0);
      go(4'h1);
      chk(START_IND[0], 1'b1);
      go(4'h0);
      chk(START_IND[0], 1'b0);
      $display("test indication done");
   endtask
   // Main sequence after eight cycles of reset
   initial begin
      repeat (8) @(posedge REF_CLK);
      ARST_N <= 1'b1;
      t_reg();
      t_route();
      t_ind();
      report_and_stop();
   end
   initial begin
      #100us;
      n_fail++;
      report_and_stop();
   end
endmodule
bind pfs_top pfs_properties chk_u (.REF_CLK, .ARST_N, .STAGE_START,
   .START_IND, .STAGE_ACTIVE, .DISPLAY_DASHES, .DEPENDENT_TIME_MODE,
   .RECLOSE_OUTPUT_FIRST, .RECLOSE_OUTPUT_THIRD, .SIGNAL_OUTPUT_THIRD,
   .HREADYOUT, .HRESP);
